// ===== rtl/otfs_defines.vh
`ifndef OTFS_DEFINES_VH
`define OTFS_DEFINES_VH

// Register byte offsets
`define OTFS_OFS_OC_FUNC     8'h00
`define OTFS_OFS_RLY_FUNC    8'h04
`define OTFS_OFS_METER_SEL   8'h08
`define OTFS_OFS_OC_POL      8'h0c
`define OTFS_OFS_RLY_POL     8'h10
`define OTFS_OFS_IRQ_STAT    8'h14
`define OTFS_OFS_IRQ_MASK    8'h18
`define OTFS_OFS_LIVE_STAT   8'h1c
`define OTFS_OFS_OL_THR      8'h20
`define OTFS_OFS_OD_THR      8'h24

// Reset values
`define OTFS_RST_OC_FUNC     8'h01
`define OTFS_RST_RLY_FUNC    8'h05
`define OTFS_RST_METER_SEL   8'h00
`define OTFS_RST_OC_POL      8'h00
`define OTFS_RST_RLY_POL     8'h01
`define OTFS_RST_OL_THR      16'hffff
`define OTFS_RST_OD_THR      16'hffff
`define OTFS_RST_IRQ_MASK    5'h00

// Output function codes
`define OTFS_FN_RUN          8'h00
`define OTFS_FN_CONST_ARR    8'h01
`define OTFS_FN_OVER_ARR     8'h02
`define OTFS_FN_OVERLOAD     8'h03
`define OTFS_FN_PID_DEV      8'h04
`define OTFS_FN_FAULT        8'h05

// Polarity codes
`define OTFS_POL_NO          8'h00
`define OTFS_POL_NC          8'h01

// Status condition vector bit positions
`define OTFS_CND_RUN         0
`define OTFS_CND_CONST_ARR   1
`define OTFS_CND_OVER_ARR    2
`define OTFS_CND_OVERLOAD    3
`define OTFS_CND_PID_DEV     4
`define OTFS_CND_FAULT       5
`define OTFS_CND_W           6

// Interrupt status bit positions
`define OTFS_IRQ_FAULT       0
`define OTFS_IRQ_SW_ON       1
`define OTFS_IRQ_SW_OFF      2
`define OTFS_IRQ_OC_CHG      3
`define OTFS_IRQ_RLY_CHG     4
`define OTFS_IRQ_W           5

`endif

// ===== rtl/otfs_out_stage.v
`timescale 1ns/1ps
`include "otfs_defines.vh"

module otfs_out_stage
(
    input  wire                    i_clk,
    input  wire                    i_sys_rst,
    input  wire [`OTFS_CND_W-1:0]  i_cond,
    input  wire [7:0]              i_func_sel,
    input  wire [7:0]              i_polarity,
    input  wire                    i_rst_level,
    output reg                     o_term_q
);

    reg sel_cond;
    reg term_d;

    // Function select; codes without a condition here read as inactive
    always @*
    begin
        case (i_func_sel)
            `OTFS_FN_RUN:       sel_cond = i_cond[`OTFS_CND_RUN];
            `OTFS_FN_CONST_ARR: sel_cond = i_cond[`OTFS_CND_CONST_ARR];
            `OTFS_FN_OVER_ARR:  sel_cond = i_cond[`OTFS_CND_OVER_ARR];
            `OTFS_FN_OVERLOAD:  sel_cond = i_cond[`OTFS_CND_OVERLOAD];
            `OTFS_FN_PID_DEV:   sel_cond = i_cond[`OTFS_CND_PID_DEV];
            `OTFS_FN_FAULT:     sel_cond = i_cond[`OTFS_CND_FAULT];
            default:            sel_cond = 1'b0;
        endcase
    end

    // Polarity stage: only the normally closed code inverts
    always @*
    begin
        term_d = sel_cond ^ (i_polarity == `OTFS_POL_NC);
    end

    // Registered every cycle so the pin never glitches on a select change
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_term_q <= i_rst_level;
        else
            o_term_q <= term_d;
    end

endmodule

// ===== rtl/otfs_top.v
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "otfs_defines.vh"

module otfs_top
(
    input  wire        i_clk,
    input  wire        i_sys_rst,
    // AHB-Lite slave
    input  wire        i_hsel,
    input  wire [7:0]  i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    // Input terminals 1..5 and mode switch
    input  wire [5:1]  i_term,
    input  wire        i_shutoff_mode_switch,
    // Drive status
    input  wire        i_run_mode,
    input  wire        i_output_on,
    input  wire        i_ramping,
    input  wire [15:0] i_out_freq,
    input  wire [15:0] i_set_freq,
    input  wire [15:0] i_out_current,
    input  wire [15:0] i_pid_error,
    input  wire        i_fault_event,
    // Decoded input functions
    output reg         o_forward_run_input,
    output reg         o_reverse_run_input,
    output reg         o_speed_preset_bit0,
    output reg         o_speed_preset_bit1,
    output reg         o_emergency_shutoff_input,
    output reg         o_trip_clear_input,
    // Output terminals
    output wire        o_open_collector,
    output wire        o_alarm_relay,
    output reg         o_irq
);

    // Terminal map states, one-hot
    localparam [2:0] ST_NORMAL  = 3'b001;
    localparam [2:0] ST_SHUTOFF = 3'b010;
    localparam [2:0] ST_AFTER   = 3'b100;

    reg [2:0]  map_q;
    reg [2:0]  map_d;
    reg        sw_q;

    // Software-visible configuration
    reg [7:0]  oc_func_q;
    reg [7:0]  rly_func_q;
    reg [7:0]  meter_sel_q;
    reg [7:0]  oc_pol_q;
    reg [7:0]  rly_pol_q;
    reg [15:0] ol_thr_q;
    reg [15:0] od_thr_q;
    reg [`OTFS_IRQ_W-1:0] irq_stat_q;
    reg [`OTFS_IRQ_W-1:0] irq_mask_q;
    reg        fault_q;

    // Bus data-phase pipeline
    reg        wr_pend_q;
    reg        rd_pend_q;
    reg [7:0]  addr_q;

    // Condition path and interrupt events
    reg [`OTFS_CND_W-1:0] cond_q;
    reg [`OTFS_CND_W-1:0] cond_d;
    reg        oc_prev_q;
    reg        rly_prev_q;
    reg [15:0] pid_abs;
    reg        trip_clear_d;
    reg [31:0] rdata_d;
    reg [`OTFS_IRQ_W-1:0] irq_set;

    // Bus decode and per-output tables
    wire       bus_take;
    wire       stat_rd;
    wire [1:0] term_out;
    wire [7:0] sel_v [0:1];
    wire [7:0] pol_v [0:1];
    wire       rst_lv [0:1];

    // Idle and busy transfers are ignored; only NONSEQ or SEQ is taken
    assign bus_take = i_hsel & i_hready & i_htrans[1];

    // Status clears when its read data is loaded, not at the address phase
    assign stat_rd  = rd_pend_q & (addr_q == `OTFS_OFS_IRQ_STAT);

    // Map follows the switch; leaving shutoff never returns to the default map
    always @*
    begin
        case (map_q)
            ST_NORMAL:  map_d = sw_q ? ST_SHUTOFF : ST_NORMAL;
            ST_SHUTOFF: map_d = sw_q ? ST_SHUTOFF : ST_AFTER;
            ST_AFTER:   map_d = sw_q ? ST_SHUTOFF : ST_AFTER;
            default:    map_d = ST_NORMAL;
        endcase
    end

    // Switch treated as synchronous, so one register stage suffices
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            map_q <= ST_NORMAL;
            sw_q  <= 1'b0;
        end
        else
        begin
            map_q <= map_d;
            sw_q  <= i_shutoff_mode_switch;
        end
    end

    // Trip clear source depends on the map
    always @*
    begin
        case (map_q)
            ST_NORMAL:  trip_clear_d = i_term[5];
            ST_SHUTOFF: trip_clear_d = i_term[4];
            ST_AFTER:   trip_clear_d = i_term[4];
            default:    trip_clear_d = 1'b0;
        endcase
    end

    // Input function decode; break contact means an open input is a stop
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_forward_run_input       <= 1'b0;
            o_reverse_run_input       <= 1'b0;
            o_speed_preset_bit0       <= 1'b0;
            o_speed_preset_bit1       <= 1'b0;
            o_emergency_shutoff_input <= 1'b0;
            o_trip_clear_input        <= 1'b0;
        end
        else
        begin
            o_forward_run_input       <= i_term[1];
            o_reverse_run_input       <= i_term[2];
            o_speed_preset_bit0       <= map_q[0] & i_term[3];
            o_speed_preset_bit1       <= map_q[0] & i_term[4];
            o_emergency_shutoff_input <= map_q[1] & ~i_term[3];
            o_trip_clear_input        <= trip_clear_d;
        end
    end

    // Fault latch; a new fault wins over a simultaneous clear
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            fault_q <= 1'b0;
        else if (i_fault_event)
            fault_q <= 1'b1;
        else if (trip_clear_d)
            fault_q <= 1'b0;
    end

    // Magnitude of the signed PID error
    always @*
    begin
        pid_abs = i_pid_error[15] ? (~i_pid_error + 16'h0001) : i_pid_error;
    end

    // Status conditions
    always @*
    begin
        cond_d = {`OTFS_CND_W{1'b0}};
        cond_d[`OTFS_CND_RUN]       = i_run_mode;
        cond_d[`OTFS_CND_CONST_ARR] = i_output_on & ~i_ramping &
                                      (i_out_freq == i_set_freq);
        cond_d[`OTFS_CND_OVER_ARR]  = i_output_on &
                                      (i_out_freq >= i_set_freq);
        cond_d[`OTFS_CND_OVERLOAD]  = i_out_current > ol_thr_q;
        cond_d[`OTFS_CND_PID_DEV]   = pid_abs > od_thr_q;
        cond_d[`OTFS_CND_FAULT]     = fault_q;
    end

    // One sample shared by both outputs keeps them coherent
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            cond_q <= {`OTFS_CND_W{1'b0}};
        else
            cond_q <= cond_d;
    end

    // Per-output select and polarity tables
    assign sel_v[0]  = oc_func_q;
    assign sel_v[1]  = rly_func_q;
    assign pol_v[0]  = oc_pol_q;
    assign pol_v[1]  = rly_pol_q;
    // Both pins sit low in reset; the relay rises once its polarity applies
    assign rst_lv[0] = 1'b0;
    assign rst_lv[1] = 1'b0;

    // One stage per output terminal
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_out
            otfs_out_stage u_stage
            (
                .i_clk       (i_clk),
                .i_sys_rst   (i_sys_rst),
                .i_cond      (cond_q),
                .i_func_sel  (sel_v[gi]),
                .i_polarity  (pol_v[gi]),
                .i_rst_level (rst_lv[gi]),
                .o_term_q    (term_out[gi])
            );
        end
    endgenerate

    // Pins come straight from the stage flip-flops
    assign o_open_collector = term_out[0];
    assign o_alarm_relay    = term_out[1];

    // Interrupt events
    always @*
    begin
        irq_set = {`OTFS_IRQ_W{1'b0}};
        irq_set[`OTFS_IRQ_FAULT]   = cond_d[`OTFS_CND_FAULT] & ~cond_q[`OTFS_CND_FAULT];
        irq_set[`OTFS_IRQ_SW_ON]   = map_d[1] & ~map_q[1];
        irq_set[`OTFS_IRQ_SW_OFF]  = map_q[1] & ~map_d[1];
        irq_set[`OTFS_IRQ_OC_CHG]  = term_out[0] ^ oc_prev_q;
        irq_set[`OTFS_IRQ_RLY_CHG] = term_out[1] ^ rly_prev_q;
    end

    // Sticky status; read clears, a same-cycle event survives the clear
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            irq_stat_q <= {`OTFS_IRQ_W{1'b0}};
            oc_prev_q  <= 1'b0;
            rly_prev_q <= 1'b0;
            o_irq      <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (stat_rd ? {`OTFS_IRQ_W{1'b0}} : irq_stat_q) | irq_set;
            oc_prev_q  <= term_out[0];
            rly_prev_q <= term_out[1];
            o_irq      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Bus: writes complete in the data phase, reads add one wait state
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_pend_q   <= 1'b0;
            rd_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            o_hrdata    <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= bus_take & i_hwrite;
            rd_pend_q <= bus_take & ~i_hwrite;
            if (bus_take)
                addr_q <= i_haddr;
            o_hreadyout <= ~(bus_take & ~i_hwrite);
            o_hresp     <= 1'b0;
            if (rd_pend_q)
                o_hrdata <= rdata_d;
        end
    end

    // Read mux; unmapped words read zero
    always @*
    begin
        rdata_d = 32'h00000000;
        case ({addr_q[7:2], 2'b00})
            `OTFS_OFS_OC_FUNC:   rdata_d[7:0]  = oc_func_q;
            `OTFS_OFS_RLY_FUNC:  rdata_d[7:0]  = rly_func_q;
            `OTFS_OFS_METER_SEL: rdata_d[7:0]  = meter_sel_q;
            `OTFS_OFS_OC_POL:    rdata_d[7:0]  = oc_pol_q;
            `OTFS_OFS_RLY_POL:   rdata_d[7:0]  = rly_pol_q;
            `OTFS_OFS_IRQ_STAT:  rdata_d[4:0]  = irq_stat_q;
            `OTFS_OFS_IRQ_MASK:  rdata_d[4:0]  = irq_mask_q;
            `OTFS_OFS_LIVE_STAT: rdata_d[13:0] = {term_out, map_q, sw_q, 2'b00, cond_q};
            `OTFS_OFS_OL_THR:    rdata_d[15:0] = ol_thr_q;
            `OTFS_OFS_OD_THR:    rdata_d[15:0] = od_thr_q;
            default:             rdata_d       = 32'h00000000;
        endcase
    end

    // Register writes; any code is stored, unsupported ones drive inactive
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            oc_func_q   <= `OTFS_RST_OC_FUNC;
            rly_func_q  <= `OTFS_RST_RLY_FUNC;
            meter_sel_q <= `OTFS_RST_METER_SEL;
            oc_pol_q    <= `OTFS_RST_OC_POL;
            rly_pol_q   <= `OTFS_RST_RLY_POL;
            ol_thr_q    <= `OTFS_RST_OL_THR;
            od_thr_q    <= `OTFS_RST_OD_THR;
            irq_mask_q  <= `OTFS_RST_IRQ_MASK;
        end
        else if (wr_pend_q)
        begin
            case ({addr_q[7:2], 2'b00})
                `OTFS_OFS_OC_FUNC:   oc_func_q   <= i_hwdata[7:0];
                `OTFS_OFS_RLY_FUNC:  rly_func_q  <= i_hwdata[7:0];
                `OTFS_OFS_METER_SEL: meter_sel_q <= i_hwdata[7:0];
                `OTFS_OFS_OC_POL:    oc_pol_q    <= i_hwdata[7:0];
                `OTFS_OFS_RLY_POL:   rly_pol_q   <= i_hwdata[7:0];
                `OTFS_OFS_IRQ_MASK:  irq_mask_q  <= i_hwdata[4:0];
                `OTFS_OFS_OL_THR:    ol_thr_q    <= i_hwdata[15:0];
                `OTFS_OFS_OD_THR:    od_thr_q    <= i_hwdata[15:0];
                default:             oc_func_q   <= oc_func_q;
            endcase
        end
    end

endmodule

// ===== test/otfs_top_asserts.sv
`timescale 1ns/1ps
module otfs_top_asserts
(
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic       i_hwrite,
    input wire logic       i_hready,
    input wire logic [5:1] i_term,
    input wire logic       i_shutoff_mode_switch,
    input wire logic       o_hreadyout,
    input wire logic       o_hresp,
    input wire logic       o_forward_run_input,
    input wire logic       o_reverse_run_input,
    input wire logic       o_speed_preset_bit0,
    input wire logic       o_emergency_shutoff_input,
    input wire logic       o_trip_clear_input,
    input wire logic       o_irq
);
    logic seen_q;
    wire  take = i_hsel && i_hready && i_htrans[1];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Switch seen on since reset; the default map is trusted only before that
    always @(posedge i_clk)
        seen_q <= !i_sys_rst && (seen_q || i_shutoff_mode_switch);

    // Terminals 1 and 2 pass through one register in every map
    property p_fwd;
        !$past(i_sys_rst) |-> o_forward_run_input == $past(i_term[1]);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward input wrong");
    property p_rev;
        !$past(i_sys_rst) |-> o_reverse_run_input == $past(i_term[2]);
    endproperty
    a_rev: assert property (p_rev) else $error("reverse input wrong");

    // Default map before the switch was ever on
    property p_dflt;
        (!$past(i_sys_rst) && !seen_q) |-> o_speed_preset_bit0 == $past(i_term[3])
            && o_trip_clear_input == $past(i_term[5]) && !o_emergency_shutoff_input;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default map wrong");

    // Three register stages from switch to decoded terminals
    property p_shut;
        i_shutoff_mode_switch [*4] |-> o_emergency_shutoff_input == !$past(i_term[3])
            && o_trip_clear_input == $past(i_term[4]) && !o_speed_preset_bit0;
    endproperty
    a_shut: assert property (p_shut) else $error("shutoff map wrong");
    property p_after;
        (seen_q && !i_shutoff_mode_switch) [*4] |-> !o_emergency_shutoff_input
            && !o_speed_preset_bit0 && o_trip_clear_input == $past(i_term[4]);
    endproperty
    a_after: assert property (p_after) else $error("after-switch map wrong");

    // Reads take one wait state, writes none; response okay in the cycle after every taken transfer
    property p_rd;
        (take && !i_hwrite) |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read wait state wrong");
    property p_wr;
        (take && i_hwrite) |=> o_hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_resp;
        take |=> !o_hresp;
    endproperty
    a_resp: assert property (p_resp) else $error("error response seen");

    c_rd: cover property (take && !i_hwrite);
    c_shut: cover property ($rose(o_emergency_shutoff_input));
    c_irq: cover property ($rose(o_irq));
endmodule

// ===== test/otfs_setpoint_model.sv
`timescale 1ns/1ps
module otfs_setpoint_model
(
    input  wire logic        i_clk,
    input  wire logic        i_run_mode,
    input  wire logic [15:0] i_req_freq,
    output      logic [15:0] o_set_freq
);
    // Operator edits land only in stop mode; running keeps the last setpoint
    always @(posedge i_clk)
        if (!i_run_mode)
            o_set_freq <= i_req_freq;
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        check_count++; \
        if ((a) !== (b)) \
        begin \
            mismatches++; \
            $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end

module testbench;
    logic        i_clk;
    logic        i_sys_rst;
    logic        i_hwrite;
    logic        i_run_mode;
    logic        i_output_on;
    logic        i_ramping;
    logic        i_fault_event;
    logic        i_shutoff_mode_switch;
    logic        e;
    logic [1:0]  i_htrans;
    logic [7:0]  i_haddr;
    logic [31:0] i_hwdata;
    logic [31:0] rd_q;
    logic [5:1]  i_term;
    logic [15:0] i_out_freq;
    logic [15:0] i_out_current;
    logic [15:0] i_pid_error;
    wire  [31:0] o_hrdata;
    wire  [15:0] set_freq;
    wire         o_hreadyout, o_hresp, o_open_collector, o_alarm_relay, o_irq;
    wire         o_fwd, o_rev, o_pre0, o_pre1, o_emr, o_trip;
    int          mismatches;
    int          check_count;
    logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28};
    logic [31:0] rv [9] = '{32'h1, 32'h5, 32'h0, 32'h0, 32'h1, 32'h0, 32'hffff, 32'hffff, 32'h0};

    otfs_top i_otfs_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(1'b1),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_term(i_term),
        .i_shutoff_mode_switch(i_shutoff_mode_switch), .i_run_mode(i_run_mode),
        .i_output_on(i_output_on), .i_ramping(i_ramping), .i_out_freq(i_out_freq),
        .i_set_freq(set_freq), .i_out_current(i_out_current), .i_pid_error(i_pid_error),
        .i_fault_event(i_fault_event), .o_forward_run_input(o_fwd),
        .o_reverse_run_input(o_rev), .o_speed_preset_bit0(o_pre0),
        .o_speed_preset_bit1(o_pre1), .o_emergency_shutoff_input(o_emr),
        .o_trip_clear_input(o_trip), .o_open_collector(o_open_collector),
        .o_alarm_relay(o_alarm_relay), .o_irq(o_irq));

    otfs_setpoint_model i_otfs_setpoint_model (.i_clk(i_clk), .i_run_mode(i_run_mode),
        .i_req_freq(16'h0100), .o_set_freq(set_freq));

    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic stop_test;
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Ready is judged at the negedge, as the rising edge will sample it
    task automatic wait_rdy;
        logic ok;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge i_clk);
            ok = o_hreadyout;
            rd_q = o_hrdata;
            @(posedge i_clk);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        i_haddr <= a;
        i_hwrite <= w;
        i_htrans <= 2'h2;
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= d;
        wait_rdy();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(a, 1'b0, 32'h0);
        `CHK(rd_q, x)
    endtask

    // Drive status so that condition c is v; thresholds sit at 0x100
    task automatic apply(input int c, input logic v);
        i_run_mode <= (c == 0) && v;
        i_output_on <= (c == 1) || (c == 2);
        i_ramping <= (c == 1) ? !v : (c == 2);
        i_out_freq <= (c == 2) ? (v ? 16'h0101 : 16'h00ff) : 16'h0100;
        i_out_current <= (c == 3 && v) ? 16'h0101 : 16'h0100;
        i_pid_error <= (c == 4 && v) ? 16'hfeff : 16'hff00;
        i_fault_event <= (c == 5) && v;
        i_term[5] <= (c == 5) && !v;
    endtask

    // Clear the latch, clear status, then raise a fault under mask m
    task automatic irq_try(input logic [31:0] m, input logic x);
        apply(5, 1'b0);
        repeat (4) @(posedge i_clk);
        i_term[5] <= 1'b0;
        bus(8'h14, 1'b0, 32'h0);
        wr(8'h18, m);
        i_fault_event <= 1'b1;
        @(posedge i_clk);
        i_fault_event <= 1'b0;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        `CHK(o_irq, x)
        @(posedge i_clk);
    endtask

    task automatic map(input logic sw, input logic [5:1] t, input logic [5:0] x);
        i_shutoff_mode_switch <= sw;
        i_term <= t;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        `CHK({o_emr, o_trip, o_pre0, o_pre1, o_rev, o_fwd}, x)
        @(posedge i_clk);
    endtask

    initial
    begin
        {i_hwrite, i_htrans, i_haddr, i_hwdata, i_term, i_shutoff_mode_switch} = '0;
        mismatches = 0;
        check_count = 0;
        i_sys_rst = 1'b1;
        apply(0, 1'b0);
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        wr(8'h28, 32'h1234);
        for (int k = 0; k < 9; k++)
            rd(ra[k], rv[k]);
        wr(8'h00, 32'hffff_ff02);
        rd(8'h00, 32'h02);
        wr(8'h20, 32'h0100);
        wr(8'h24, 32'h0100);
        for (int c = 0; c < 7; c++)
            for (int p = 0; p < 2; p++)
                for (int v = 0; v < 2; v++)
                begin
                    wr(8'h00, 32'(c));
                    wr(8'h04, 32'(c));
                    wr(8'h0c, 32'(p));
                    wr(8'h10, 32'(1 - p));
                    apply(c, v[0]);
                    repeat (4) @(posedge i_clk);
                    i_fault_event <= 1'b0;
                    i_term[5] <= 1'b0;
                    repeat (4) @(posedge i_clk);
                    @(negedge i_clk);
                    e = (c < 6) && v;
                    `CHK(o_open_collector, e ^ p[0])
                    `CHK(o_alarm_relay, e ^ !p[0])
                    @(posedge i_clk);
                end
        irq_try(32'h01, 1'b1);
        rd(8'h14, 32'h01);
        irq_try(32'h00, 1'b0);
        map(1'b0, 5'b01101, 6'b001101);
        map(1'b0, 5'b10010, 6'b010010);
        map(1'b1, 5'b10000, 6'b100000);
        map(1'b1, 5'b01100, 6'b010000);
        map(1'b0, 5'b10000, 6'b000000);
        map(1'b0, 5'b01001, 6'b010001);
        rd(8'h14, 32'h07);
        rd(8'h14, 32'h00);
        rd(8'h1c, 32'h1800);
        stop_test();
    end

    // Watchdog far beyond the few hundred cycles the run needs
    initial
    begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule

bind otfs_top otfs_top_asserts i_otfs_top_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .i_term(i_term), .i_shutoff_mode_switch(i_shutoff_mode_switch),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_forward_run_input(o_forward_run_input),
    .o_reverse_run_input(o_reverse_run_input), .o_speed_preset_bit0(o_speed_preset_bit0),
    .o_emergency_shutoff_input(o_emergency_shutoff_input),
    .o_trip_clear_input(o_trip_clear_input), .o_irq(o_irq));
